/* bench/host_bus_model.sv */
// host side register bus master for the streaming port block
`timescale 1ns/1ns

module host_bus_model
	import dio_pkg::*;
(
	input  wire logic        clock,
	output apb_in_t          apb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// ----------------------------------------------------------------
	// bus transfers
	// ----------------------------------------------------------------
	initial apb = '0;

	// setup, then access held until pready; watchdog guards a dead slave
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clock);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
			pwdata: d};
		@(posedge clock);
		apb.penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		apb <= '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q,
		output logic e);
		xfer(1'b0, a, 32'h0, q, e);
	endtask
endmodule

/* bench/stream_dio_trigger_irq_test.sv */
// self-checking bench for the streaming port block
`timescale 1ns/1ns
`include "dio_cfg.svh"

module stream_dio_trigger_irq_test;
	import dio_pkg::*;

	logic        clock;
	logic        resetn;
	apb_in_t     apb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        trig_in;
	logic        trig_out;
	logic [15:0] pins_in;
	logic [15:0] pins_o;
	logic [15:0] pins_oe;
	logic [15:0] pins_i;
	logic [15:0] flt;
	logic [31:0] q;
	logic        e;
	int          err_total;
	int          total_checks;

	// ----------------------------------------------------------------
	// harness
	// ----------------------------------------------------------------
	// released output pins toggle so a stale level never reads back
	assign pins_i = (pins_o & pins_oe) | (flt & ~pins_oe);

	stream_dio_trigger_irq i_stream_dio_trigger_irq (
		.clock                    (clock),
		.resetn                   (resetn),
		.apb                      (apb),
		.prdata                   (prdata),
		.pready                   (pready),
		.pslverr                  (pslverr),
		.input_port_pins          (pins_in),
		.input_stream_trigger_pin (trig_in),
		.output_stream_trigger_pin(trig_out),
		.output_port_pins_i       (pins_i),
		.output_port_pins_o       (pins_o),
		.output_port_pins_oe      (pins_oe),
		.irq                      (irq)
	);

	host_bus_model i_host_bus_model (
		.clock  (clock),
		.apb    (apb),
		.prdata (prdata),
		.pready (pready),
		.pslverr(pslverr)
	);

	// free-running clock and float pattern
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) flt <= ~flt;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		i_host_bus_model.rd(a, q, e);
		chk($sformatf("reg %h", a), x, q);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_host_bus_model.wr(a, d);
	endtask

	// pin change, then enough edges for sync plus status update
	task automatic pin(input logic [15:0] v);
		@(posedge clock);
		pins_in <= v;
		repeat (6) @(posedge clock);
	endtask

	task automatic waito(input logic [15:0] v);
		int n;
		n = 0;
		while (pins_o !== v && n < 80) begin
			@(posedge clock);
			n++;
		end
		chk("output pins", {16'h0, v}, {16'h0, pins_o});
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset;
		chk("oe", 32'h0, {16'h0, pins_oe});
		chk("irq", 32'h0, {31'h0, irq});
		chk("pready", 32'h1, {31'h0, pready});
		rdc(`OFF_CTRL, 32'h0);
		rdc(`OFF_IVL_IN, `IVL_RST);
		i_host_bus_model.rd(8'h3C, q, e);
		chk("slverr", 32'h1, {31'h0, e});
		$display("reset test done");
	endtask

	task t_change;
		wr(`OFF_IRQ_MASK, 32'h0080_0004);
		pin(16'h000C);
		chk("irq quiet", 32'h0, {31'h0, irq});
		rdc(`OFF_IRQ_STAT, 32'h0);
		pin(16'h008C);
		chk("irq rise", 32'h1, {31'h0, irq});
		rdc(`OFF_IRQ_STAT, 32'h0080_0000);
		pin(16'h0088);
		rdc(`OFF_IRQ_STAT, 32'h0080_0004);
		chk("irq held", 32'h1, {31'h0, irq});
		wr(`OFF_IRQ_STAT, 32'h0080_0004);
		rdc(`OFF_IRQ_STAT, 32'h0);
		chk("irq ack", 32'h0, {31'h0, irq});
		wr(`OFF_IRQ_MASK, 32'h0);
		$display("change interrupt test done");
	endtask

	task t_tirq;
		wr(`OFF_TIRQ, 32'h3);
		trig_in <= 1'b1;
		repeat (6) @(posedge clock);
		chk("irq trig", 32'h1, {31'h0, irq});
		rdc(`OFF_TIRQ, 32'h0001_0003);
		trig_out <= 1'b1;
		repeat (6) @(posedge clock);
		rdc(`OFF_TIRQ, 32'h0003_0003);
		wr(`OFF_TIRQ, 32'h0003_0000);
		rdc(`OFF_TIRQ, 32'h0);
		$display("trigger interrupt test done");
	endtask

	// start on pin 0 rise, stop on trigger pin fall, sample per edge
	task t_trig;
		wr(`OFF_TSEL, 32'h4);
		wr(`OFF_IN_START, 32'h0001_0000);
		wr(`OFF_CTRL, 32'h5);
		// the start edge itself is not a sample
		pin(16'h0001);
		repeat (40) @(posedge clock);
		rdc(`OFF_LEVEL, 32'h0);
		pin(16'h0000);
		pin(16'h0003);
		rdc(`OFF_LEVEL, 32'h1);
		trig_in <= 1'b0;
		repeat (6) @(posedge clock);
		pin(16'h0000);
		pin(16'h0001);
		rdc(`OFF_LEVEL, 32'h1);
		wr(`OFF_CTRL, 32'h0);
		wr(`OFF_TSEL, 32'h0);
		wr(`OFF_IN_START, 32'h0);
		rdc(`OFF_IN_DATA, 32'h3);
		rdc(`OFF_LEVEL, 32'h0);
		$display("trigger sample test done");
	endtask

	task t_timer_in;
		pins_in <= 16'h1234;
		wr(`OFF_IVL_IN, 32'h1);
		wr(`OFF_CTRL, 32'h1);
		repeat (40) @(posedge clock);
		wr(`OFF_CTRL, 32'h0);
		i_host_bus_model.rd(`OFF_LEVEL, q, e);
		chk("in level", 32'h1, {31'h0, q[13:0] > 14'h7});
		rdc(`OFF_IN_DATA, 32'h1234);
		$display("timer input test done");
	endtask

	task t_out;
		wr(`OFF_IVL_OUT, 32'h1);
		wr(`OFF_OUT_DATA, 32'hA5A5);
		wr(`OFF_OUT_DATA, 32'h5A5A);
		wr(`OFF_OUT_DATA, 32'h0F0F);
		wr(`OFF_CTRL, 32'h2);
		@(posedge clock);
		chk("oe on", 32'hFFFF, {16'h0, pins_oe});
		waito(16'hA5A5);
		waito(16'h5A5A);
		waito(16'h0F0F);
		wr(`OFF_CTRL, 32'h0);
		@(posedge clock);
		chk("oe off", 32'h0, {16'h0, pins_oe});
		$display("timer output test done");
	endtask

	task t_wrap;
		wr(`OFF_IVL_OUT, 32'h9);
		wr(`OFF_OUT_DATA, 32'h1111);
		wr(`OFF_OUT_DATA, 32'h2222);
		wr(`OFF_CTRL, 32'h12);
		waito(16'h1111);
		waito(16'h2222);
		waito(16'h1111);
		waito(16'h2222);
		wr(`OFF_CTRL, 32'h0);
		$display("wraparound test done");
	endtask

	task t_fill;
		for (int i = 0; i < 8200; i++)
			wr(`OFF_OUT_DATA, 32'(i));
		i_host_bus_model.rd(`OFF_LEVEL, q, e);
		chk("out full", 32'h2000, {18'h0, q[29:16]});
		$display("fifo depth test done");
	endtask

	// ----------------------------------------------------------------
	// sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		pins_in = 16'h0;
		trig_in = 1'b0;
		trig_out = 1'b0;
		flt = 16'h0;
		err_total = 0;
		total_checks = 0;
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		t_reset;
		t_change;
		t_tirq;
		t_trig;
		t_timer_in;
		t_out;
		t_wrap;
		t_fill;
		test_done;
	end

	// whole run is about 25k cycles; over twice that means a hang
	initial begin
		repeat (60000) @(posedge clock);
		err_total++;
		test_done;
	end
endmodule

/* hw/dio_cfg.svh */
// register map, field positions, reset values and timing counts
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL      8'h00
`define OFF_STAT      8'h04
`define OFF_IVL_IN    8'h08
`define OFF_IVL_OUT   8'h0C
`define OFF_IN_DATA   8'h10
`define OFF_OUT_DATA  8'h14
`define OFF_LEVEL     8'h18
`define OFF_IRQ_MASK  8'h1C
`define OFF_IRQ_STAT  8'h20
`define OFF_TIRQ      8'h24
`define OFF_IN_START  8'h28
`define OFF_IN_STOP   8'h2C
`define OFF_OUT_START 8'h30
`define OFF_OUT_STOP  8'h34
`define OFF_TSEL      8'h38

// ----------------------------------------------------------------
// control and status bit positions
// ----------------------------------------------------------------
`define CB_IN_ARM   0
`define CB_OUT_ARM  1
`define CB_IN_TRIG  2
`define CB_OUT_TRIG 3
`define CB_WRAP     4
`define CB_BURST    5
`define SB_OVF      8
`define SB_UNF      9

// ----------------------------------------------------------------
// reset values, depth, tick generation (66 of 250 MHz)
// ----------------------------------------------------------------
`define IVL_RST     32'h0000_0002
`define FIFO_DEPTH  14'h2000
`define CLK_MHZ     9'h0FA
`define TICK_MHZ    9'h042

`endif

/* hw/dio_pkg.sv */
// types shared by the streaming digital port block
package dio_pkg;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_WAIT = 2'b01,
		S_RUN  = 2'b10
	} strm_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_in_t;

	// sync vector: [15:0] in, [16] input_stream_trigger_pin, [32:17] out, [33] output_stream_trigger_pin
	typedef struct packed {
		logic [33:0] s1;
		logic [33:0] s2;
		logic [33:0] prv;
		logic [5:0]  ctrl;
		logic [31:0] ivl_in;
		logic [31:0] ivl_out;
		logic [31:0] st_in;
		logic [31:0] sp_in;
		logic [31:0] st_out;
		logic [31:0] sp_out;
		logic [31:0] irq_mask;
		logic [31:0] irq_stat;
		logic [7:0]  tsel;
		logic [1:0]  tirq_en;
		logic [1:0]  tirq_st;
		logic [7:0]  acc;
		logic [31:0] tm_in;
		logic [31:0] tm_out;
		strm_t       fs_in;
		strm_t       fs_out;
		logic [12:0] in_wr;
		logic [12:0] in_rd;
		logic [12:0] out_wr;
		logic [12:0] out_rd;
		logic [12:0] out_base;
		logic [13:0] in_cnt;
		logic [13:0] out_cnt;
		logic        ovf;
		logic        unf;
		logic        pop;
		logic [15:0] pins;
		logic [31:0] prdata;
	} state_t;

endpackage

/* hw/stream_dio_trigger_irq.sv */
// streaming digital in/out ports with triggers and change interrupt
//
// Function
// (R01) port one inputs, port two outputs, 16 bits
// (R02) timer mode paces words through FIFO
// (R03) trigger mode moves one word per edge
// (R04) burst moves up to 8192 words locally
// (R05) wraparound replays output buffer from start
// (R06) short wrap buffers replay without host
// (R07) per-source start/stop enables with edge choice
// (R08) enabled trigger sources ORed, first wins
// (R09) stream sources: own trigger pin, own port
// (R10) masked edge on input raises interrupt
// (R11) change monitoring only on input port
// (R12) mask: falls bits 15-0, rises 31-16
// (R13) status: falls bits 15-0, rises 31-16
// (R14) unmasked pin edges are ignored
// (R15) trigger pins usable as interrupt sources
// (R16) each stream FIFO holds 8192 16-bit words
// (R17) tick derived from 66 MHz rate
// (R18) ports undriven after reset until configured
// (R19) pins synchronised, compared with previous sample
// (R20) status held until host acknowledges it
`timescale 1ns/1ns
`include "dio_cfg.svh"

module stream_dio_trigger_irq
	import dio_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire apb_in_t     apb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] input_port_pins,
	input  wire logic        input_stream_trigger_pin,
	input  wire logic        output_stream_trigger_pin,
	input  wire logic [15:0] output_port_pins_i,
	output logic [15:0]      output_port_pins_o,
	output logic [15:0]      output_port_pins_oe,
	output logic             irq
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// edge match against a 32-bit rise/fall mask plus trigger pin
	function automatic logic hit(input logic [15:0] r, f,
		input logic [31:0] m, input logic rt, ft,
		input logic [1:0] e);
		return |(r & m[31:16]) | |(f & m[15:0]) |
			(rt & e[1]) | (ft & e[0]);
	endfunction

	// tick timer step: {expired, next count}
	function automatic logic [32:0] tstep(input logic run, tk,
		input logic [31:0] tm, iv);
		if (!run)
			return 33'h0;
		if (!tk)
			return {1'b0, tm};
		if (tm >= iv - 32'h1)
			return {1'b1, 32'h0};
		return {1'b0, tm + 32'h1};
	endfunction

	state_t      st;
	state_t      n;
	logic [33:0] rise;
	logic [33:0] fall;
	logic [8:0]  sum;
	logic        tick;
	logic        in_go;
	logic        in_end;
	logic        out_go;
	logic        out_end;
	logic        in_free;
	logic        out_free;
	logic [32:0] te_in;
	logic [32:0] te_out;
	logic        strb_in;
	logic        strb_out;
	logic        in_full;
	logic        out_full;
	logic        out_empty;
	logic        push_in;
	logic        pop_in;
	logic        push_o;
	logic        pop_o;
	logic        wr_acc;
	logic        rd_set;
	logic        ok;
	logic [31:0] rv;
	logic [15:0] in_q;
	logic [15:0] out_q;
	logic [15:0] in_mem  [0:`FIFO_DEPTH-1];
	logic [15:0] out_mem [0:`FIFO_DEPTH-1];

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		n = st;
		wr_acc = apb.psel & apb.penable & apb.pwrite;
		rd_set = apb.psel & ~apb.penable & ~apb.pwrite;

		// two-flop sync, previous sample for edges
		n.s1 = {output_stream_trigger_pin, output_port_pins_i,
			input_stream_trigger_pin, input_port_pins}; // R19
		n.s2 = st.s1;
		n.prv = st.s2;
		rise = st.s2 & ~st.prv; // R19
		fall = ~st.s2 & st.prv;

		// fractional accumulator: 66 ticks per 250 clocks
		sum = {1'b0, st.acc} + `TICK_MHZ; // R17
		tick = sum >= `CLK_MHZ;
		n.acc = tick ? 8'(sum - `CLK_MHZ) : sum[7:0];

		// register read mux, unmapped flags slave error
		ok = 1'b1;
		rv = 32'h0;
		case (apb.paddr)
			`OFF_CTRL:      rv = {26'h0, st.ctrl};
			`OFF_STAT:      rv = {22'h0, st.unf, st.ovf, 4'h0,
				st.fs_out, st.fs_in};
			`OFF_IVL_IN:    rv = st.ivl_in;
			`OFF_IVL_OUT:   rv = st.ivl_out;
			`OFF_IN_DATA:   rv = (st.in_cnt != 14'h0) ?
				{16'h0, in_q} : 32'h0;
			`OFF_OUT_DATA:  rv = 32'h0;
			`OFF_LEVEL:     rv = {2'h0, st.out_cnt, 2'h0, st.in_cnt};
			`OFF_IRQ_MASK:  rv = st.irq_mask;
			`OFF_IRQ_STAT:  rv = st.irq_stat; // R13
			`OFF_TIRQ:      rv = {14'h0, st.tirq_st, 14'h0,
				st.tirq_en};
			`OFF_IN_START:  rv = st.st_in;
			`OFF_IN_STOP:   rv = st.sp_in;
			`OFF_OUT_START: rv = st.st_out;
			`OFF_OUT_STOP:  rv = st.sp_out;
			`OFF_TSEL:      rv = {24'h0, st.tsel};
			default:        ok = 1'b0;
		endcase

		// read data is fixed in the setup cycle; pop at access
		pop_in = apb.psel & apb.penable & ~apb.pwrite & st.pop;
		if (rd_set) begin
			n.prdata = rv;
			n.pop = (apb.paddr == `OFF_IN_DATA) &&
				(st.in_cnt != 14'h0);
		end else if (apb.psel & apb.penable) begin
			n.pop = 1'b0;
		end

		// writes; clears come first so a same-cycle set wins
		out_full = st.out_cnt == `FIFO_DEPTH;
		push_o = wr_acc & (apb.paddr == `OFF_OUT_DATA) & ~out_full;
		if (wr_acc) begin
			case (apb.paddr)
				`OFF_CTRL:      n.ctrl = apb.pwdata[5:0];
				`OFF_STAT: begin
					if (apb.pwdata[`SB_OVF])
						n.ovf = 1'b0;
					if (apb.pwdata[`SB_UNF])
						n.unf = 1'b0;
				end
				`OFF_IVL_IN:    n.ivl_in = apb.pwdata;
				`OFF_IVL_OUT:   n.ivl_out = apb.pwdata;
				`OFF_IRQ_MASK:  n.irq_mask = apb.pwdata; // R12
				`OFF_IRQ_STAT:
					n.irq_stat = st.irq_stat & ~apb.pwdata; // R20
				`OFF_TIRQ: begin
					n.tirq_en = apb.pwdata[1:0];
					n.tirq_st = st.tirq_st & ~apb.pwdata[17:16];
				end
				`OFF_IN_START:  n.st_in = apb.pwdata; // R07
				`OFF_IN_STOP:   n.sp_in = apb.pwdata;
				`OFF_OUT_START: n.st_out = apb.pwdata;
				`OFF_OUT_STOP:  n.sp_out = apb.pwdata;
				`OFF_TSEL:      n.tsel = apb.pwdata[7:0];
				default: ;
			endcase
		end

		// change monitor on the input port only, set wins
		n.irq_stat = n.irq_stat |
			{rise[15:0] & st.irq_mask[31:16],
			fall[15:0] & st.irq_mask[15:0]}; // R10 R11 R13 R14
		n.tirq_st = n.tirq_st | (st.tirq_en &
			{rise[33] | fall[33], rise[16] | fall[16]}); // R15

		// start/stop conditions, all sources ORed
		in_go = hit(rise[15:0], fall[15:0], st.st_in,
			rise[16], fall[16], st.tsel[1:0]); // R08 R09
		in_end = hit(rise[15:0], fall[15:0], st.sp_in,
			rise[16], fall[16], st.tsel[3:2]); // R07
		out_go = hit(rise[32:17], fall[32:17], st.st_out,
			rise[33], fall[33], st.tsel[5:4]); // R08 R09
		out_end = hit(rise[32:17], fall[32:17], st.sp_out,
			rise[33], fall[33], st.tsel[7:6]); // R07
		// no start source at all means start on arm
		in_free = (st.st_in == 32'h0) && (st.tsel[1:0] == 2'h0);
		out_free = (st.st_out == 32'h0) && (st.tsel[5:4] == 2'h0);

		// sample pacing: timer expiry or qualifying edge
		te_in = tstep(st.fs_in == S_RUN, tick, st.tm_in, st.ivl_in);
		te_out = tstep(st.fs_out == S_RUN, tick, st.tm_out,
			st.ivl_out);
		n.tm_in = te_in[31:0];
		n.tm_out = te_out[31:0];
		strb_in = (st.fs_in == S_RUN) && (st.ctrl[`CB_IN_TRIG] ?
			in_go : te_in[32]); // R02 R03
		strb_out = (st.fs_out == S_RUN) && (st.ctrl[`CB_OUT_TRIG] ?
			out_go : te_out[32]); // R02 R03

		// input FIFO; a capture into a full FIFO is lost
		in_full = st.in_cnt == `FIFO_DEPTH; // R16
		push_in = strb_in & ~in_full; // R01
		if (strb_in & in_full)
			n.ovf = 1'b1;
		n.in_wr = st.in_wr + 13'(push_in);
		n.in_rd = st.in_rd + 13'(pop_in);
		n.in_cnt = st.in_cnt + 14'(push_in) - 14'(pop_in);

		// output buffer; wrap walks base..wr and keeps the words
		out_empty = st.out_cnt == 14'h0;
		pop_o = 1'b0;
		if (strb_out) begin
			if (out_empty) begin
				n.unf = 1'b1;
			end else begin
				n.pins = out_q; // R01
				pop_o = ~st.ctrl[`CB_WRAP];
				if (st.ctrl[`CB_WRAP] &&
					st.out_rd + 13'h1 == st.out_wr)
					n.out_rd = st.out_base; // R05 R06
				else
					n.out_rd = st.out_rd + 13'h1;
			end
		end
		n.out_wr = st.out_wr + 13'(push_o);
		n.out_cnt = st.out_cnt + 14'(push_o) - 14'(pop_o); // R16

		// input stream sequencer; burst ends when FIFO is full
		unique case (st.fs_in)
			S_IDLE: begin
				if (st.ctrl[`CB_IN_ARM])
					n.fs_in = S_WAIT;
			end
			S_WAIT: begin
				if (!st.ctrl[`CB_IN_ARM])
					n.fs_in = S_IDLE;
				else if (in_go | in_free)
					n.fs_in = S_RUN; // R08
			end
			S_RUN: begin
				if (!st.ctrl[`CB_IN_ARM] | in_end |
					(st.ctrl[`CB_BURST] & in_full))
					n.fs_in = S_IDLE; // R04 R08
			end
			default: n.fs_in = S_IDLE;
		endcase

		// output stream sequencer; burst ends when drained
		unique case (st.fs_out)
			S_IDLE: begin
				if (st.ctrl[`CB_OUT_ARM])
					n.fs_out = S_WAIT;
			end
			S_WAIT: begin
				if (!st.ctrl[`CB_OUT_ARM]) begin
					n.fs_out = S_IDLE;
				end else if (out_go | out_free) begin
					n.fs_out = S_RUN; // R08
					n.out_base = st.out_rd;
				end
			end
			S_RUN: begin
				if (!st.ctrl[`CB_OUT_ARM] | out_end |
					(st.ctrl[`CB_BURST] & out_empty &
					~st.ctrl[`CB_WRAP]))
					n.fs_out = S_IDLE; // R04 R08
			end
			default: n.fs_out = S_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
			st.ivl_in <= `IVL_RST;
			st.ivl_out <= `IVL_RST;
		end else begin
			st <= n;
		end
	end

	// word stores; bypass covers a write to the next read slot
	always_ff @(posedge clock) begin
		if (push_in)
			in_mem[st.in_wr] <= st.s2[15:0];
		if (push_in && st.in_wr == n.in_rd)
			in_q <= st.s2[15:0];
		else
			in_q <= in_mem[n.in_rd];
		if (push_o)
			out_mem[st.out_wr] <= apb.pwdata[15:0];
		if (push_o && st.out_wr == n.out_rd)
			out_q <= apb.pwdata[15:0];
		else
			out_q <= out_mem[n.out_rd];
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// zero-wait slave: read data was latched in setup
	assign prdata = st.prdata;
	assign pready = 1'b1;
	assign pslverr = apb.psel & apb.penable & ~ok;
	assign output_port_pins_o = st.pins;
	// port left undriven until the output stream is armed
	assign output_port_pins_oe = {16{st.ctrl[`CB_OUT_ARM]}}; // R18
	assign irq = |st.irq_stat | |st.tirq_st; // R10 R20

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// armed and waiting when a qualifying start edge is seen
	sequence s_in_arm_go;
		st.fs_in == S_WAIT && st.ctrl[`CB_IN_ARM] && in_go;
	endsequence

	property p_start;
		s_in_arm_go |=> st.fs_in == S_RUN;
	endproperty
	a_start: assert property (p_start) // R08
		else $error("input stream did not start on trigger");

	property p_stop;
		st.fs_in == S_RUN && in_end |=> st.fs_in == S_IDLE;
	endproperty
	a_stop: assert property (p_stop) // R07
		else $error("input stream did not stop on trigger");

	property p_irq_set;
		|(fall[15:0] & st.irq_mask[15:0]) |=> irq ##1 irq;
	endproperty
	a_irq_set: assert property (p_irq_set) // R10
		else $error("masked falling edge gave no interrupt");

	property p_ignore;
		((st.irq_stat & ~$past(st.irq_stat)) &
		~$past({rise[15:0] & st.irq_mask[31:16],
		fall[15:0] & st.irq_mask[15:0]})) == 32'h0;
	endproperty
	a_ignore: assert property (p_ignore) // R14
		else $error("status bit set without masked edge");

	property p_ack;
		wr_acc && apb.paddr == `OFF_IRQ_STAT && apb.pwdata[23] &&
		!(rise[7] && st.irq_mask[23]) |=> !st.irq_stat[23];
	endproperty
	a_ack: assert property (p_ack) // R20
		else $error("acknowledged status bit stayed set");

	property p_push;
		push_in && !pop_in |=> st.in_cnt == $past(st.in_cnt) + 14'h1;
	endproperty
	a_push: assert property (p_push) // R02
		else $error("input capture did not grow the FIFO");

	property p_cap;
		st.in_cnt <= `FIFO_DEPTH && st.out_cnt <= `FIFO_DEPTH;
	endproperty
	a_cap: assert property (p_cap) // R16
		else $error("FIFO level beyond 8192 words");

	property p_wrap;
		strb_out && !out_empty && st.ctrl[`CB_WRAP] &&
		st.out_rd + 13'h1 == st.out_wr
		|=> st.out_rd == $past(st.out_base) && st.out_cnt != 14'h0;
	endproperty
	a_wrap: assert property (p_wrap) // R05
		else $error("wrap did not restart at first word");

	property p_tick;
		tick |=> !tick ##1 !tick;
	endproperty
	a_tick: assert property (p_tick) // R17
		else $error("tick rate above 66 MHz");

	property p_oe;
		!st.ctrl[`CB_OUT_ARM] |-> output_port_pins_oe == 16'h0000;
	endproperty
	a_oe: assert property (p_oe) // R18
		else $error("output port driven while not armed");

endmodule
